// ===== scd_host.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module scd_host (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  scd_link_if.host        link,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata
);

  typedef enum logic [3:0] {
    H_IDLE    = 4'h0,
    H_WR_GAP  = 4'h1,
    H_RD_WAIT = 4'h2,
    H_RD_CAP  = 4'h3,
    H_UP_WAIT = 4'h4,
    H_UP_CAP  = 4'h5,
    H_LO_WAIT = 4'h6,
    H_LO_CAP  = 4'h7
  } scd_host_st_t;

  typedef struct packed {
    scd_host_st_t state;
    logic [3:0]   pend;
    logic         dumping;
    logic         dump_done;
    logic [7:0]   cmd_addr;
    logic [7:0]   cmd_wdata;
    logic [7:0]   rd_up;
    logic [7:0]   rd_lo;
    logic [7:0]   pix_idx;
    logic [7:0]   view_idx;
    logic         lwr;
    logic         lrd;
    logic [7:0]   laddr;
    logic [7:0]   lwdata;
    logic [7:0]   urdata;
  } scd_host_state_t;

  scd_host_state_t s;
  scd_host_state_t next_s;
  logic [5:0]      pix_mem [256];
  logic            pix_we;
  logic            engine_busy;

  assign engine_busy = (s.state != H_IDLE) || (s.pend != 4'h0);
  // Keep a pixel only when flagged valid and at the expected address
  assign pix_we = (s.state == H_LO_CAP) && s.dumping && !link.rdata[scd_pkg::BIT_PIX_INVALID]
                  && (s.rd_up == s.pix_idx);

  // Next-state logic
  always_comb
  begin
    next_s        = s;
    next_s.lwr    = 1'b0;
    next_s.lrd    = 1'b0;
    next_s.urdata = 8'h00;

    // User register port
    if (wr)
    begin
      case (addr)
        scd_pkg::HREG_ADDR:    next_s.cmd_addr  = wdata;
        scd_pkg::HREG_WDATA:   next_s.cmd_wdata = wdata;
        scd_pkg::HREG_PIX_IDX: next_s.view_idx  = wdata;
        scd_pkg::HREG_CTRL:
        begin
          // Orders while busy are dropped
          if (!engine_busy)
          begin
            next_s.pend = wdata[3:0];
          end
        end
        default: next_s.pend = s.pend;
      endcase
    end
    if (rd)
    begin
      case (addr)
        scd_pkg::HREG_ADDR:     next_s.urdata = s.cmd_addr;
        scd_pkg::HREG_WDATA:    next_s.urdata = s.cmd_wdata;
        scd_pkg::HREG_CTRL:     next_s.urdata = {4'h0, s.pend};
        scd_pkg::HREG_STATUS:   next_s.urdata = {5'h00, link.busy, s.dump_done, engine_busy};
        scd_pkg::HREG_RD_UP:    next_s.urdata = s.rd_up;
        scd_pkg::HREG_RD_LO:    next_s.urdata = s.rd_lo;
        scd_pkg::HREG_PIX_IDX:  next_s.urdata = s.view_idx;
        scd_pkg::HREG_PIX_DATA: next_s.urdata = {2'b00, pix_mem[s.view_idx]};
        default:                next_s.urdata = 8'h00;
      endcase
    end

    // Link engine
    unique case (s.state)
      H_IDLE:
      begin
        // Nothing goes out while the self test runs
        if (s.pend != 4'h0 && !link.busy)
        begin
          next_s.pend = 4'h0;
          if (s.pend[scd_pkg::CMD_DUMP])
          begin
            next_s.lwr       = 1'b1;
            next_s.laddr     = scd_pkg::ADDR_CONFIG;
            next_s.lwdata    = scd_pkg::DUMP_START_CONFIG;
            next_s.dumping   = 1'b1;
            next_s.dump_done = 1'b0;
            next_s.pix_idx   = scd_pkg::PIX_FIRST;
            next_s.state     = H_WR_GAP;
          end
          else if (s.pend[scd_pkg::CMD_PAIR])
          begin
            next_s.lrd   = 1'b1;
            next_s.laddr = scd_pkg::ADDR_OUT_HI;
            next_s.state = H_UP_WAIT;
          end
          else if (s.pend[scd_pkg::CMD_READ])
          begin
            next_s.lrd   = 1'b1;
            next_s.laddr = s.cmd_addr;
            next_s.state = H_RD_WAIT;
          end
          else
          begin
            next_s.lwr    = 1'b1;
            next_s.laddr  = s.cmd_addr;
            next_s.lwdata = s.cmd_wdata;
            next_s.state  = H_WR_GAP;
          end
        end
      end
      H_WR_GAP:
      begin
        // One spare cycle lets a self-test busy become visible
        if (s.dumping)
        begin
          next_s.lrd   = 1'b1;
          next_s.laddr = scd_pkg::ADDR_OUT_HI;
          next_s.state = H_UP_WAIT;
        end
        else
        begin
          next_s.state = H_IDLE;
        end
      end
      H_RD_WAIT: next_s.state = H_RD_CAP;
      H_RD_CAP:
      begin
        next_s.rd_lo = link.rdata;
        next_s.state = H_IDLE;
      end
      H_UP_WAIT: next_s.state = H_UP_CAP;
      H_UP_CAP:
      begin
        // High byte first, low byte straight after
        next_s.rd_up = link.rdata;
        next_s.lrd   = 1'b1;
        next_s.laddr = scd_pkg::ADDR_OUT_LO;
        next_s.state = H_LO_WAIT;
      end
      H_LO_WAIT: next_s.state = H_LO_CAP;
      H_LO_CAP:
      begin
        next_s.rd_lo = link.rdata;
        next_s.state = H_IDLE;
        if (s.dumping)
        begin
          if (pix_we && s.pix_idx == scd_pkg::PIX_LAST)
          begin
            next_s.lwr       = 1'b1;
            next_s.laddr     = scd_pkg::ADDR_CONFIG;
            next_s.lwdata    = scd_pkg::DUMP_END_CONFIG;
            next_s.dumping   = 1'b0;
            next_s.dump_done = 1'b1;
            next_s.state     = H_WR_GAP;
          end
          else
          begin
            // Poll again until the flag drops
            if (pix_we)
            begin
              next_s.pix_idx = s.pix_idx + 8'h01;
            end
            next_s.lrd   = 1'b1;
            next_s.laddr = scd_pkg::ADDR_OUT_HI;
            next_s.state = H_UP_WAIT;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s       <= '0;
      s.state <= H_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Captured image; contents need no reset
  always_ff @(posedge ref_clk)
  begin
    if (pix_we)
    begin
      pix_mem[s.pix_idx] <= link.rdata[5:0];
    end
  end

  assign link.wr    = s.lwr;
  assign link.rd    = s.lrd;
  assign link.addr  = s.laddr;
  assign link.wdata = s.lwdata;
  assign rdata      = s.urdata;

endmodule : scd_host

// ===== scd_pkg.sv
package scd_pkg;

  // Register map seen on the link
  localparam logic [7:0] ADDR_RSVD_A = 8'h08;
  localparam logic [7:0] ADDR_RSVD_B = 8'h09;
  localparam logic [7:0] ADDR_CONFIG = 8'h0a;
  localparam logic [7:0] ADDR_RSVD_C = 8'h0b;
  localparam logic [7:0] ADDR_OUT_LO = 8'h0c;
  localparam logic [7:0] ADDR_OUT_HI = 8'h0d;

  // Configuration field positions
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_GATING     = 6;
  localparam int BIT_SELF_TEST  = 5;
  localparam int BIT_CPI        = 4;
  localparam int BIT_DUMP       = 3;
  localparam int BIT_AWAKE      = 0;
  localparam logic [7:0] CONFIG_RESET   = 8'h00;
  localparam logic [7:0] CONFIG_RW_MASK = 8'h59;

  // Pixel readout
  localparam int         BIT_PIX_INVALID  = 7;
  localparam logic [7:0] PIX_FIRST        = 8'h00;
  localparam logic [7:0] PIX_LAST         = 8'hff;
  localparam logic [7:0] PIX_INVALID_WORD = 8'h80;

  // Self-test signatures
  localparam logic [15:0] SIG_RESULT1 = 16'hdbfd;
  localparam logic [15:0] SIG_RESULT2 = 16'h20d6;

  // Timing
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned FRAME_RATE_FPS   = 1500;
  localparam int unsigned FRAME_CYCLES     = CLK_HZ / FRAME_RATE_FPS;
  localparam int unsigned SLEEP_TIME_MS    = 1000;
  localparam int unsigned SLEEP_CYCLES     = CLK_HZ / 1000 * SLEEP_TIME_MS;
  localparam int unsigned SELFTEST_TIME_US = 2000;
  localparam int unsigned SELFTEST_CYCLES  = CLK_HZ / 1_000_000 * SELFTEST_TIME_US;

  // Host controller user registers
  localparam logic [2:0] HREG_ADDR     = 3'h0;
  localparam logic [2:0] HREG_WDATA    = 3'h1;
  localparam logic [2:0] HREG_CTRL     = 3'h2;
  localparam logic [2:0] HREG_STATUS   = 3'h3;
  localparam logic [2:0] HREG_RD_UP    = 3'h4;
  localparam logic [2:0] HREG_RD_LO    = 3'h5;
  localparam logic [2:0] HREG_PIX_IDX  = 3'h6;
  localparam logic [2:0] HREG_PIX_DATA = 3'h7;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ  = 1;
  localparam int CMD_PAIR  = 2;
  localparam int CMD_DUMP  = 3;
  localparam logic [7:0] DUMP_START_CONFIG = 8'h09;
  localparam logic [7:0] DUMP_END_CONFIG   = 8'h01;

endpackage : scd_pkg

// ===== scd_link_if.sv
`timescale 1ns/1ps
interface scd_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       busy;

  modport dev (input addr, input wdata, input wr, input rd, output rdata, output busy);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input busy);
endinterface : scd_link_if

// ===== scd_dev.sv
`timescale 1ns/1ps
// Overview of operation
// - Config register at 0x0a, resets to zero
// - Soft-reset bit restores defaults, reads zero
// - Gating bit: LED on only while shutter open
// - Self-test bit yields 16-bit result, reads zero
// - Test completion restores configuration defaults
// - Host configures only after self test ends
// - Host waits longer for self-test completion
// - Resolution bit selects 400 or 800 cpi
// - Dump bit streams 256 pixels out
// - Sleep after one idle second unless awake
// - Read-only 16-bit output, high above low
// - Host reads high byte, then optionally low
// - Self test leaves a fixed signature
// - Dump start loads first address and value
// - Low byte bit 7 invalid flag, bits 0-5 intensity
// - Pixel address advances once per frame
// - Host polls valid, saves, clears dump bit
// - Host sets always-awake before dumping; scd_host sets it in the same write as the dump bit
// - Addresses 00 to ff, sixteen per row
// - Motion status resolution bit mirrors config
module scd_dev #(
  parameter int unsigned FRAME_CYCLES    = scd_pkg::FRAME_CYCLES,
  parameter int unsigned SLEEP_CYCLES    = scd_pkg::SLEEP_CYCLES,
  parameter int unsigned SELFTEST_CYCLES = scd_pkg::SELFTEST_CYCLES,
  parameter logic [15:0] SIGNATURE       = scd_pkg::SIG_RESULT1
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  scd_link_if.dev         link,
  input  wire logic       motion_seen,
  input  wire logic       shutter_open,
  input  wire logic [5:0] pix_value,
  output logic      [7:0] pix_addr,
  output logic            led_on,
  output logic            cpi_800,
  output logic            motion_res,
  output logic            asleep,
  output logic            dump_active
);

  typedef struct packed {
    logic [7:0]  cfg;
    logic        busy;
    logic [31:0] st_cnt;
    logic [31:0] frame_cnt;
    logic [31:0] idle_cnt;
    logic        asleep;
    logic        led;
    logic        capt;
    logic [7:0]  out_hi;
    logic [7:0]  out_lo;
    logic [7:0]  rdata;
  } scd_dev_state_t;

  scd_dev_state_t s;
  scd_dev_state_t next_s;
  logic           frame_tick;
  logic           cfg_write;

  // Register read decode; unmapped and reserved addresses give zero
  function automatic logic [7:0] scd_read(
    input logic [7:0] a,
    input logic [7:0] cfg,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic [7:0] r;
    r = 8'h00;
    case (a)
      scd_pkg::ADDR_CONFIG: r = cfg & scd_pkg::CONFIG_RW_MASK;
      scd_pkg::ADDR_OUT_HI: r = hi;
      scd_pkg::ADDR_OUT_LO: r = lo;
      default:              r = 8'h00;
    endcase
    return r;
  endfunction : scd_read

  // Frame timebase paces the readout
  assign frame_tick = (s.frame_cnt == FRAME_CYCLES - 1);
  // Writes are refused while the self test runs, the host polls busy
  assign cfg_write  = link.wr && !s.busy && (link.addr == scd_pkg::ADDR_CONFIG);

  // Next-state logic
  always_comb
  begin
    next_s           = s;
    next_s.frame_cnt = frame_tick ? 32'h0000_0000 : s.frame_cnt + 32'h0000_0001;

    // Sleep timer; any motion or the awake bit keeps the sensor up
    if (motion_seen || s.cfg[scd_pkg::BIT_AWAKE])
    begin
      next_s.idle_cnt = 32'h0000_0000;
      next_s.asleep   = 1'b0;
    end
    else if (s.idle_cnt >= SLEEP_CYCLES - 1)
    begin
      next_s.asleep = 1'b1;
    end
    else
    begin
      next_s.idle_cnt = s.idle_cnt + 32'h0000_0001;
    end

    // Pixel readout: address first, value sampled one cycle later
    if (s.capt)
    begin
      next_s.out_lo = {2'b00, pix_value};
      next_s.capt   = 1'b0;
    end
    else if (frame_tick && s.cfg[scd_pkg::BIT_DUMP] && !s.busy && s.out_hi != scd_pkg::PIX_LAST)
    begin
      next_s.out_hi = s.out_hi + 8'h01;
      next_s.out_lo = scd_pkg::PIX_INVALID_WORD;
      next_s.capt   = 1'b1;
    end

    // Link reads; data stands until the next read
    if (link.rd)
    begin
      next_s.rdata = scd_read(link.addr, s.cfg, s.out_hi, s.out_lo);
    end

    // Configuration writes
    if (cfg_write)
    begin
      if (link.wdata[scd_pkg::BIT_SOFT_RESET])
      begin
        // Soft reset; output pair keeps its undefined contents
        next_s.cfg       = scd_pkg::CONFIG_RESET;
        next_s.busy      = 1'b0;
        next_s.st_cnt    = 32'h0000_0000;
        next_s.frame_cnt = 32'h0000_0000;
        next_s.idle_cnt  = 32'h0000_0000;
        next_s.asleep    = 1'b0;
        next_s.capt      = 1'b0;
      end
      else
      begin
        // Strobe bits and reserved bits are not stored
        next_s.cfg = link.wdata & scd_pkg::CONFIG_RW_MASK;
        if (link.wdata[scd_pkg::BIT_DUMP] && !s.cfg[scd_pkg::BIT_DUMP])
        begin
          next_s.out_hi = scd_pkg::PIX_FIRST;
          next_s.out_lo = scd_pkg::PIX_INVALID_WORD;
          next_s.capt   = 1'b1;
        end
        if (link.wdata[scd_pkg::BIT_SELF_TEST])
        begin
          next_s.busy   = 1'b1;
          next_s.st_cnt = 32'h0000_0000;
          next_s.capt   = 1'b0;
        end
      end
    end

    // Self test run; completion wipes configuration state
    if (s.busy)
    begin
      if (s.st_cnt >= SELFTEST_CYCLES - 1)
      begin
        next_s.busy     = 1'b0;
        next_s.cfg      = scd_pkg::CONFIG_RESET;
        next_s.out_hi   = SIGNATURE[15:8];
        next_s.out_lo   = SIGNATURE[7:0];
        next_s.idle_cnt = 32'h0000_0000;
        next_s.asleep   = 1'b0;
        next_s.capt     = 1'b0;
      end
      else
      begin
        next_s.st_cnt = s.st_cnt + 32'h0000_0001;
      end
    end

    // LED: dark when asleep, gated by shutter when asked
    next_s.led = !next_s.asleep && (!next_s.cfg[scd_pkg::BIT_GATING] || shutter_open);
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s           <= '0;
      s.cfg       <= scd_pkg::CONFIG_RESET;
      s.led       <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign link.rdata  = s.rdata;
  assign link.busy   = s.busy;
  assign pix_addr    = s.out_hi;
  assign led_on      = s.led;
  assign cpi_800     = s.cfg[scd_pkg::BIT_CPI];
  assign motion_res  = s.cfg[scd_pkg::BIT_CPI];
  assign asleep      = s.asleep;
  assign dump_active = s.cfg[scd_pkg::BIT_DUMP];

endmodule : scd_dev

// ===== scd_link_properties.sv
`timescale 1ns/1ps
module scd_link_properties #(
  parameter int unsigned SELFTEST_CYCLES = 20,
  parameter logic [15:0] SIGNATURE       = 16'hdbfd
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       busy
);
  logic [7:0]  shadow;
  logic [15:0] busy_len;
  logic        sig_ok;
  wire         cfg_wr = wr && addr == scd_pkg::ADDR_CONFIG && !busy;

  // Expected config and signature state; test end wins over any write
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      shadow   <= 8'h00;
      busy_len <= 16'h0000;
      sig_ok   <= 1'b0;
    end
    else
    begin
      busy_len <= busy ? busy_len + 16'h0001 : 16'h0000;
      if ($fell(busy))
      begin
        shadow <= 8'h00;
        sig_ok <= 1'b1;
      end
      else if (cfg_wr)
      begin
        shadow <= wdata[7] ? 8'h00 : (wdata & scd_pkg::CONFIG_RW_MASK);
        if (wdata[3] && !wdata[7])
          sig_ok <= 1'b0; // A dump overwrites the pair
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  strobe_excl_a: assert property (!(wr && rd)) else $error("both strobes high");
  busy_start_a: assert property (cfg_wr && wdata[5] && !wdata[7] |=> busy) else $error("no busy");
  busy_len_a: assert property ($fell(busy) |-> busy_len == 16'(SELFTEST_CYCLES)) else $error("busy length");
  cfg_read_a: assert property (rd && addr == 8'h0a |=> rdata == shadow) else $error("config value");
  rsvd_zero_a: assert property (rd && (addr == 8'h08 || addr == 8'h09 || addr == 8'h0b) |=> rdata == 8'h00)
    else $error("reserved not zero");
  sig_high_a: assert property (rd && addr == 8'h0d && sig_ok |=> rdata == SIGNATURE[15:8]) else $error("sig hi");
  sig_low_a: assert property (rd && addr == 8'h0c && sig_ok |=> rdata == SIGNATURE[7:0]) else $error("sig lo");
  rdata_hold_a: assert property (!rd |=> $stable(rdata)) else $error("read data moved");
  pix_flag_a: assert property (rd && addr == 8'h0c && shadow[3] |=> !rdata[6]) else $error("pixel bit 6");

  // Main scenarios reached
  cover property ($fell(busy));
  cover property (rd && addr == 8'h0c && shadow[3] ##1 !rdata[7]);
  cover property (cfg_wr && wdata[7]);
endmodule : scd_link_properties

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  localparam int FRAME = 40;
  localparam int SLEEP = 200;
  localparam int STEST = 20;
  logic       ref_clk      = 1'b0;
  logic       reset        = 1'b1;
  logic [2:0] h_addr       = 3'h0;
  logic [7:0] h_wdata      = 8'h00;
  logic       h_wr         = 1'b0;
  logic       h_rd         = 1'b0;
  logic [7:0] h_rdata;
  logic       motion_seen  = 1'b1;
  logic       shutter_open = 1'b1;
  logic [5:0] pix_value;
  logic [7:0] pix_addr;
  logic       led_on;
  logic       cpi_800;
  logic       motion_res;
  logic       asleep;
  logic       dump_active;
  int         err_count    = 0;
  int         checks_done  = 0;

  scd_link_if link ();
  scd_dev #(.FRAME_CYCLES(FRAME), .SLEEP_CYCLES(SLEEP), .SELFTEST_CYCLES(STEST)) scd_dev_inst (
    .ref_clk(ref_clk), .reset(reset), .link(link), .motion_seen(motion_seen), .shutter_open(shutter_open),
    .pix_value(pix_value), .pix_addr(pix_addr), .led_on(led_on), .cpi_800(cpi_800), .motion_res(motion_res),
    .asleep(asleep), .dump_active(dump_active));
  scd_host scd_host_inst (.ref_clk(ref_clk), .reset(reset), .link(link), .addr(h_addr), .wdata(h_wdata),
    .wr(h_wr), .rd(h_rd), .rdata(h_rdata));
  scd_link_properties #(.SELFTEST_CYCLES(STEST), .SIGNATURE(scd_pkg::SIG_RESULT1)) scd_link_properties_inst (
    .ref_clk(ref_clk), .reset(reset), .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata), .busy(link.busy));

  always #20 ref_clk = ~ref_clk;

  // Pixel array answers its address at once, as a sensor would
  function automatic logic [5:0] pixf(input logic [7:0] a);
    return a[5:0] ^ {a[7:6], 4'h9};
  endfunction : pixf
  always_comb pix_value = pixf(pix_addr);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // User-port strobes, one cycle each
  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    h_addr  <= a;
    h_wdata <= d;
    h_wr    <= 1'b1;
    @(posedge ref_clk);
    h_wr <= 1'b0;
  endtask : hw
  task automatic hr(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    h_addr <= a;
    h_rd   <= 1'b1;
    @(posedge ref_clk);
    h_rd <= 1'b0;
    #1 d = h_rdata; // Stands one cycle only
  endtask : hr
  // Launch a link command, then poll until host and link are idle
  task automatic cmd(input logic [7:0] c);
    logic [7:0] s;
    int         n;
    s = 8'h05;
    hw(scd_pkg::HREG_CTRL, c);
    repeat (2) @(posedge ref_clk);
    for (n = 0; n < 20000 && (s[0] || s[2]); n++)
      hr(scd_pkg::HREG_STATUS, s);
    chk(16'(s & 8'h05), 16'h0000);
  endtask : cmd
  task automatic dw(input logic [7:0] a, input logic [7:0] v);
    hw(scd_pkg::HREG_ADDR, a);
    hw(scd_pkg::HREG_WDATA, v);
    cmd(8'h01);
  endtask : dw
  task automatic dr(input logic [7:0] a, output logic [7:0] d);
    hw(scd_pkg::HREG_ADDR, a);
    cmd(8'h02);
    hr(scd_pkg::HREG_RD_LO, d);
  endtask : dr
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] rs [4] = '{8'h08, 8'h09, 8'h0b, 8'h3f};
    dr(8'h0a, d);
    chk(16'(d), 16'h0000);
    foreach (rs[i])
    begin
      dr(rs[i], d);
      chk(16'(d), 16'h0000);
    end
    chk(16'(led_on), 16'h0001);
    chk(16'(cpi_800), 16'h0000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_config();
    logic [7:0] d;
    dw(8'h0a, 8'h53);
    dr(8'h0a, d);
    chk(16'(d), 16'h0051);
    chk(16'(cpi_800), 16'h0001);
    chk(16'(motion_res), 16'h0001);
    @(posedge ref_clk) shutter_open <= 1'b0;
    tick(2);
    chk(16'(led_on), 16'h0000);
    dw(8'h0a, 8'h80);
    dr(8'h0a, d);
    chk(16'(d), 16'h0000);
    chk(16'(led_on), 16'h0001);
    chk(16'(cpi_800), 16'h0000);
    @(posedge ref_clk) shutter_open <= 1'b1;
    $display("t_config done");
  endtask : t_config

  task automatic t_selftest();
    logic [7:0] d;
    dw(8'h0a, 8'h30);
    cmd(8'h04);
    hr(scd_pkg::HREG_RD_UP, d);
    chk(16'(d), 16'(scd_pkg::SIG_RESULT1[15:8]));
    hr(scd_pkg::HREG_RD_LO, d);
    chk(16'(d), 16'(scd_pkg::SIG_RESULT1[7:0]));
    dr(8'h0a, d);
    chk(16'(d), 16'h0000);
    chk(16'(cpi_800), 16'h0000);
    $display("t_selftest done");
  endtask : t_selftest

  task automatic t_sleep();
    @(posedge ref_clk) motion_seen <= 1'b0;
    tick(SLEEP - 10);
    chk(16'(asleep), 16'h0000);
    tick(20);
    chk(16'(asleep), 16'h0001);
    chk(16'(led_on), 16'h0000);
    dw(8'h0a, 8'h01);
    tick(SLEEP + 20);
    chk(16'(asleep), 16'h0000);
    $display("t_sleep done");
  endtask : t_sleep

  task automatic t_dump();
    logic [7:0] d;
    logic [7:0] ix [5] = '{8'h00, 8'h01, 8'h0f, 8'h10, 8'hff};
    cmd(8'h08);
    hr(scd_pkg::HREG_STATUS, d);
    chk(16'(d[1]), 16'h0001);
    chk(16'(dump_active), 16'h0000);
    chk(16'(pix_addr), 16'h00ff);
    foreach (ix[i])
    begin
      hw(scd_pkg::HREG_PIX_IDX, ix[i]);
      hr(scd_pkg::HREG_PIX_DATA, d);
      chk(16'(d), 16'({2'b00, pixf(ix[i])}));
    end
    dr(8'h0a, d);
    chk(16'(d), 16'h0001);
    $display("t_dump done");
  endtask : t_dump

  task automatic print_verdict();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    tick(3);
    reset <= 1'b0;
    t_reset();
    t_config();
    t_selftest();
    t_sleep();
    t_dump();
    print_verdict();
  end

  // Dump needs about 256 frames; allow generous slack
  initial
  begin
    tick(60000);
    err_count++;
    print_verdict();
  end
endmodule : tb
